// ---- hw/wbc_pkg.sv ----
package wbc_pkg;

	// Avalon register byte addresses
	localparam logic [3:0] ADDR_CFG      = 4'h0;
	localparam logic [3:0] ADDR_CTRL     = 4'h4;
	localparam logic [3:0] ADDR_STATUS   = 4'h8;
	localparam logic [3:0] ADDR_IRQ_STAT = 4'hc;
	localparam logic [3:0] ADDR_IRQ_MASK = 4'h0;

	// Configuration word field positions
	localparam int WINSZ_LSB       = 24;
	localparam int FEN_BIT         = 23;
	localparam int WIN_DISABLE_BIT = 22;
	localparam int PS_LSB          = 16;
	localparam int PS_W            = 5;

	// Control register bits
	localparam int CTRL_ON_BIT  = 0;
	localparam int CTRL_CLR_BIT = 1;
	// Key bit of a mask write through the configuration word address
	localparam int MASK_WR_BIT  = 31;

	// Interrupt status bits
	localparam int IRQ_EARLY_BIT = 0;
	localparam int IRQ_TMO_BIT   = 1;
	localparam int IRQ_W         = 2;

	localparam logic [4:0]  PS_MAX_CODE  = 5'h14;
	localparam logic [31:0] CFG_DEFAULT  = 32'hffff_ffff;
	localparam logic [1:0]  IRQ_RESET    = 2'h0;
	localparam logic        STALL_RESET  = 1'h1;

	// Window size codes
	localparam logic [1:0] WIN_25  = 2'h3;
	localparam logic [1:0] WIN_375 = 2'h2;
	localparam logic [1:0] WIN_50  = 2'h1;
	localparam logic [1:0] WIN_75  = 2'h0;

endpackage : wbc_pkg

// ---- hw/wbc_decode.sv ----
`timescale 1ns/1ps
`default_nettype none
module wbc_decode (
	// Configuration word
	input  wire logic [31:0] cfg_word,
	// Decoded fields
	output logic [4:0]  ps_code,
	output logic        win_enable,
	output logic        forced_on,
	output logic [1:0]  win_size
);
	logic [4:0] raw_ps;

	always_comb begin
		raw_ps     = cfg_word[wbc_pkg::PS_LSB +: wbc_pkg::PS_W];
		ps_code    = (raw_ps > wbc_pkg::PS_MAX_CODE) ? wbc_pkg::PS_MAX_CODE : raw_ps;
		win_enable = ~cfg_word[wbc_pkg::WIN_DISABLE_BIT];
		forced_on  = cfg_word[wbc_pkg::FEN_BIT];
		win_size   = cfg_word[wbc_pkg::WINSZ_LSB +: 2];
	end
endmodule : wbc_decode
`default_nettype wire

// ---- hw/wbc_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module wbc_top #(
	parameter int PRE_W = 4
) (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        resetn,
	// Boot configuration word, sampled after reset
	input  wire logic [31:0] boot_config_word_one,
	// Avalon-MM slave
	input  wire logic [3:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	// Watchdog results
	output logic             wd_reset_req,
	output logic             irq
);
	logic [4:0] ps_code;
	logic       win_enable;
	logic       forced_on;
	logic [1:0] win_size;

	localparam int IRQ_W_L = wbc_pkg::IRQ_W;

	typedef struct packed {
		logic        loaded;
		logic [31:0] cfg;
		logic        sw_on;
		logic [PRE_W-1:0] pre;
		logic [20:0] cnt;
		logic [IRQ_W_L-1:0] ists;
		logic [IRQ_W_L-1:0] imask;
		logic        rst_req;
		logic        irq;
		logic        stall;
		logic [31:0] rdata;
	} wbc_state_s;

	wbc_state_s st_r;
	wbc_state_s st_nxt;

	// Decoding kept apart so the same field map feeds status reads
	wbc_decode u_dec (
		.cfg_word   (st_r.cfg),
		.ps_code    (ps_code),
		.win_enable (win_enable),
		.forced_on  (forced_on),
		.win_size   (win_size)
	);

	logic        running;
	logic [20:0] period;
	logic [20:0] open_at;
	logic        wr_acc;
	logic        rd_acc;
	logic        clr_req;
	logic        early;
	logic        timeout;
	logic [IRQ_W_L-1:0] ev;
	logic [31:0] status_word;

	always_comb begin
		running = st_r.loaded & (forced_on | st_r.sw_on);
		period  = 21'(21'h1 << ps_code);
		// Window opens once the closed share of the period has elapsed
		case (win_size)
			wbc_pkg::WIN_25:  open_at = 21'(period - (period >> 2));
			wbc_pkg::WIN_375: open_at = 21'(period - (period >> 2) - (period >> 3));
			wbc_pkg::WIN_50:  open_at = 21'(period >> 1);
			wbc_pkg::WIN_75:  open_at = 21'(period >> 2);
			default:          open_at = 21'h0;
		endcase
	end

	always_comb begin
		st_nxt = st_r;
		// Writes land on the edge that sees waitrequest low; reads fetch one edge earlier
		wr_acc = avs_write & ~st_r.stall;
		rd_acc = avs_read & st_r.stall;
		clr_req = wr_acc && avs_address == wbc_pkg::ADDR_CTRL
			&& avs_writedata[wbc_pkg::CTRL_CLR_BIT];
		early   = 1'b0;
		timeout = 1'b0;
		ev      = '0;
		status_word = {25'h0, win_size, ps_code == wbc_pkg::PS_MAX_CODE,
			win_enable, forced_on, running, st_r.rst_req};

		// Strap the configuration word once after reset release
		if (!st_r.loaded) begin
			st_nxt.cfg    = boot_config_word_one;
			st_nxt.loaded = 1'b1;
		end

		// Software may switch on or off in any mode; forced mode ignores off
		if (wr_acc && avs_address == wbc_pkg::ADDR_CTRL) begin
			st_nxt.sw_on = avs_writedata[wbc_pkg::CTRL_ON_BIT];
		end

		if (running) begin
			st_nxt.pre = st_r.pre + 1'b1;
			if (clr_req) begin
				if (win_enable && st_r.cnt < open_at) begin
					early = 1'b1;
				end
				st_nxt.cnt = '0;
				st_nxt.pre = '0;
			end else if (&st_r.pre) begin
				if (st_r.cnt >= 21'(period - 21'h1)) begin
					timeout    = 1'b1;
					st_nxt.cnt = '0;
				end else begin
					st_nxt.cnt = st_r.cnt + 21'h1;
				end
			end
		end else begin
			st_nxt.cnt = '0;
			st_nxt.pre = '0;
		end

		if (early || timeout) begin
			st_nxt.rst_req = 1'b1;
		end

		ev[wbc_pkg::IRQ_EARLY_BIT] = early;
		ev[wbc_pkg::IRQ_TMO_BIT]   = timeout;
		if (wr_acc && avs_address == wbc_pkg::ADDR_IRQ_STAT) begin
			st_nxt.ists = st_r.ists & ~avs_writedata[IRQ_W_L-1:0];
		end
		// Set wins over a same-cycle clear
		st_nxt.ists = st_nxt.ists | ev;
		// Mask shares the read-only word's address, keyed by the top data bit
		if (wr_acc && avs_address == wbc_pkg::ADDR_IRQ_MASK
			&& avs_writedata[wbc_pkg::MASK_WR_BIT]) begin
			st_nxt.imask = avs_writedata[IRQ_W_L-1:0];
		end
		st_nxt.irq = |(st_nxt.ists & st_nxt.imask);

		// Waitrequest drops for one cycle, the cycle after a request is first seen
		st_nxt.stall = ~((avs_read | avs_write) & st_r.stall);
		if (rd_acc) begin
			case (avs_address)
				wbc_pkg::ADDR_CFG:      st_nxt.rdata = st_r.cfg;
				wbc_pkg::ADDR_CTRL:     st_nxt.rdata = {31'h0, st_r.sw_on};
				wbc_pkg::ADDR_STATUS:   st_nxt.rdata = status_word;
				wbc_pkg::ADDR_IRQ_STAT: st_nxt.rdata = {30'h0, st_r.ists};
				default:                st_nxt.rdata = 32'h0;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			st_r         <= '0;
			st_r.cfg     <= wbc_pkg::CFG_DEFAULT;
			st_r.ists    <= wbc_pkg::IRQ_RESET;
			st_r.imask   <= wbc_pkg::IRQ_RESET;
			st_r.stall   <= wbc_pkg::STALL_RESET;
		end else begin
			st_r <= st_nxt;
		end
	end

	always_comb begin
		avs_readdata    = st_r.rdata;
		avs_waitrequest = st_r.stall;
		wd_reset_req    = st_r.rst_req;
		irq             = st_r.irq;
	end
endmodule : wbc_top
`default_nettype wire

// ---- bench/wbc_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
module wbc_chk (
	// Watched top ports
	input wire logic        clk,
	input wire logic        resetn,
	input wire logic [31:0] boot_config_word_one,
	input wire logic [3:0]  avs_address,
	input wire logic        avs_read,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	input wire logic        wd_reset_req
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	wire logic [31:0] c = boot_config_word_one;
	wire logic [31:0] d = avs_readdata;
	wire logic [4:0]  p = c[20:16];
	sequence s_st; avs_read && !avs_waitrequest && avs_address == 4'h8; endsequence
	property p_win; s_st |-> d[6:5] == c[25:24]; endproperty
	a_win: assert property (p_win) else $error("window");
	property p_run; s_st |-> !c[23] || d[2:1] == 2'h3; endproperty
	a_run: assert property (p_run) else $error("forced");
	property p_fen; s_st |-> d[2] == c[23]; endproperty
	a_fen: assert property (p_fen) else $error("enable");
	property p_mode; s_st |-> d[3] == !c[22]; endproperty
	a_mode: assert property (p_mode) else $error("mode");
	property p_ps; s_st |-> p > 5'h14 || d[4] == (p == 5'h14); endproperty
	a_ps: assert property (p_ps) else $error("scale");
	property p_big; s_st |-> p <= 5'h14 || d[4]; endproperty
	a_big: assert property (p_big) else $error("big scale");
	// Sticky until reset, so a late clear cannot hide an error
	property p_hold; wd_reset_req |=> wd_reset_req; endproperty
	a_hold: assert property (p_hold) else $error("reset dropped");
endmodule : wbc_chk
bind wbc_top wbc_chk u_wbc_chk (.clk, .resetn, .boot_config_word_one, .avs_address,
	.avs_read, .avs_readdata, .avs_waitrequest, .wd_reset_req);
`default_nettype wire

// ---- bench/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic        clk = 1'b0, resetn = 1'b0, rd = 1'b0, wr = 1'b0, rq, irq, wq;
	logic [3:0]  a = 4'h0;
	logic [31:0] wd = 32'h0, cfg = 32'h0, q, rdat;
	int          num_errors = 0, comparisons = 0;
	wbc_top u_wbc_top (.clk(clk), .resetn(resetn), .boot_config_word_one(cfg),
		.avs_address(a), .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
		.avs_readdata(rdat), .avs_waitrequest(wq), .wd_reset_req(rq), .irq(irq));
	initial forever #4 clk = ~clk;
	initial begin
		// Roughly ten times the expected run of about 500 cycles
		#40000 num_errors++;
		summarize();
	end
	task automatic summarize();
		$display("errors %0d of %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : summarize
	task automatic chk(input logic [31:0] g, e);
		comparisons++;
		if (g !== e) begin
			num_errors++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [3:0] x, input logic [31:0] d);
		int n;
		rd <= !w;
		wr <= w;
		a <= x;
		wd <= d;
		@(posedge clk);
		// No wait limit here; a stuck slave is caught by the 40000 ns time limit
		for (n = 0; wq !== 1'b0; n++) @(posedge clk);
		q = rdat;
		chk(32'(n), 32'h1);
		rd <= 1'b0;
		wr <= 1'b0;
		@(posedge clk);
	endtask : bus
	task automatic rst(input logic [31:0] c);
		resetn <= 1'b0;
		cfg <= c;
		repeat (12) @(posedge clk);
		resetn <= 1'b1;
		repeat (2) @(posedge clk);
	endtask : rst
	task automatic t_dec();
		logic [4:0] ps [4] = '{5'h00, 5'h13, 5'h14, 5'h1f};
		for (int i = 0; i < 4; i++) begin
			rst({6'h3f, 2'(i), i[0], i[1], 1'b1, ps[i], 16'hffff});
			bus(1'b0, 4'h8, 32'h0);
			chk(q[6:1], {2'(i), ps[i] >= 5'h14, !i[1], i[0], i[0]});
		end
		$display("dec ok");
	endtask : t_dec
	task automatic t_run();
		for (int f = 0; f < 2; f++) begin
			rst({8'hff, f[0], 23'h63ffff});
			bus(1'b1, 4'h4, {31'h0, !f[0]});
			bus(1'b0, 4'h8, 32'h0);
			chk(q[1], 1'b1);
		end
		bus(1'b0, 4'h2, 32'h0);
		chk(q, 32'h0);
		$display("run ok");
	endtask : t_run
	task automatic t_win();
		rst(32'hfda3_ffff);
		bus(1'b1, 4'h0, 32'h8000_0003);
		repeat (90) @(posedge clk);
		bus(1'b1, 4'h4, 32'h3);
		// Past the unrestarted timeout, so only a restart keeps this quiet
		repeat (50) @(posedge clk);
		chk({rq, irq}, 2'b00);
		repeat (160) @(posedge clk);
		chk({rq, irq}, 2'b11);
		$display("win ok");
	endtask : t_win
	task automatic t_early();
		rst(32'hfda3_ffff);
		bus(1'b1, 4'h4, 32'h3);
		repeat (4) @(posedge clk);
		chk({rq, irq}, 2'b10);
		bus(1'b1, 4'h0, 32'h8000_0001);
		repeat (2) @(posedge clk);
		chk(irq, 1'b1);
		bus(1'b1, 4'hc, 32'h1);
		bus(1'b0, 4'hc, 32'h0);
		chk({q[0], irq}, 2'b00);
		$display("early ok");
	endtask : t_early
	initial begin
		t_dec();
		t_run();
		t_win();
		t_early();
		summarize();
	end
endmodule : tb_top
`default_nettype wire
